// ---- tb/reset_and_power_mode_control_tb.sv ----
`timescale 1ns/1ps
module reset_and_power_mode_control_tb;
    import reset_power_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic clock_error = 1'b0;
    logic [7:0] reg_rdata, rv, mr, cc;
    logic module_reset, processor_reset, coef_clear_start, exec_rom_select, subsys_power_en, charge_pump_en;
    logic digital_supply_en, in_standby, in_powerdown, left_mute_request, right_mute_request;
    int rom_pulses = 0;
    int failures = 0;
    int comparisons = 0;
    int n, m;
    // Rows: address, write data, read-back expected
    logic [23:0] rows [7] = '{24'h031111, 24'h03FF11, 24'h030000, 24'h020000, 24'h028080, 24'h05FF00, 24'h011000};
    reset_power_control uut (.mclk(mclk), .reset_n(reset_n), .reg_write(reg_write), .reg_read(reg_read),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .clock_error(clock_error),
        .module_reset(module_reset), .processor_reset(processor_reset), .coef_clear_start(coef_clear_start),
        .exec_rom_select(exec_rom_select), .subsys_power_en(subsys_power_en), .charge_pump_en(charge_pump_en),
        .digital_supply_en(digital_supply_en), .in_standby(in_standby), .in_powerdown(in_powerdown),
        .left_mute_request(left_mute_request), .right_mute_request(right_mute_request));
    initial
    begin
        forever #2.5 mclk = ~mclk;
    end
    always @(posedge mclk) if (exec_rom_select === 1'b1) rom_pulses <= rom_pulses + 1;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Strobes are one cycle wide; taken at the rising edge in between
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        {reg_write, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge mclk);
        reg_write = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(negedge mclk);
        {reg_read, reg_addr} = {1'b1, a};
        @(negedge mclk);
        reg_read = 1'b0;
        rv = reg_rdata;
    endtask
    // Bounded wait for run mode; a hang ends the run
    task automatic restart_time(output int c);
        c = 0;
        while (subsys_power_en !== 1'b1 && c < 3000)
        begin
            @(negedge mclk);
            c++;
        end
        if (c >= 3000)
        begin
            failures++;
            close_out();
        end
    endtask
    initial
    begin
        repeat (2) @(posedge mclk);
        check({processor_reset, charge_pump_en, digital_supply_en, module_reset, subsys_power_en, 3'b0}, 8'hC0);
        @(negedge mclk);
        reset_n = 1'b1;
        rd(8'h01); check(rv, 8'h00);
        rd(8'h02); check(rv, 8'h80);
        restart_time(n);
        for (int i = 0; i < 7; i++)
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]); check(rv, rows[i][7:0]);
            check({7'b0, module_reset}, 8'h00);
        end
        wr(8'h03, 8'h11); check({3'b0, left_mute_request, 3'b0, right_mute_request}, 8'h11);
        wr(8'h02, 8'h00); check({7'b0, processor_reset}, 8'h00);
        $display("Test register rows done");
        wr(8'h02, 8'h10);
        repeat (2) @(negedge mclk);
        check({in_standby, in_powerdown, charge_pump_en, subsys_power_en, digital_supply_en, 3'b0}, 8'hA8);
        {mr, cc} = 16'h0000;
        wr(8'h01, 8'h10);
        repeat (60)
        begin
            if (module_reset === 1'b1) mr++;
            if (coef_clear_start === 1'b1) cc++;
            @(negedge mclk);
        end
        check(mr, 8'h14);
        check(cc, 8'h01);
        rd(8'h01); check(rv, 8'h00);
        $display("Test module reset done");
        wr(8'h02, 8'h11);
        repeat (2) @(negedge mclk);
        check({in_standby, in_powerdown, charge_pump_en, subsys_power_en, 4'b0}, 8'h40);
        wr(8'h02, 8'h00);
        restart_time(n);
        wr(8'h02, 8'h10);
        repeat (3) @(negedge mclk);
        wr(8'h02, 8'h00);
        restart_time(m);
        check({6'b0, n >= 1990 && n <= 2015, m >= 190 && m <= 215}, 8'h03);
        $display("Test power modes done");
        clock_error = 1'b1;
        repeat (2) @(negedge mclk);
        check({6'b0, in_standby, subsys_power_en}, 8'h02);
        clock_error = 1'b0;
        restart_time(n);
        $display("Test clock error done");
        // Register reset issued from standby only
        wr(8'h02, 8'h10);
        m = rom_pulses;
        wr(8'h01, 8'h01);
        repeat (3) @(negedge mclk);
        check({rom_pulses - m == 1, processor_reset, 6'b0}, 8'hC0);
        rd(8'h02); check(rv, 8'h80);
        rd(8'h03); check(rv, 8'h00);
        rd(8'h01); check(rv, 8'h00);
        $display("Test register reset done");
        close_out();
    end
endmodule // reset_and_power_mode_control_tb

// ---- tb/reset_power_checker.sv ----
`timescale 1ns/1ps
module reset_power_checker
import reset_power_pkg::*;
(
    // Clock, reset, register port, clock error
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic clock_error,
    // Design outputs
    input wire logic module_reset,
    input wire logic processor_reset,
    input wire logic coef_clear_start,
    input wire logic exec_rom_select,
    input wire logic subsys_power_en,
    input wire logic charge_pump_en,
    input wire logic digital_supply_en,
    input wire logic in_standby,
    input wire logic in_powerdown,
    input wire logic left_mute_request,
    input wire logic right_mute_request
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic w_rc;
    logic w_pm;
    logic [11:0] off_count;
    assign w_rc = reg_write && reg_addr == ADDR_RESET_CONTROL;
    assign w_pm = reg_write && reg_addr == ADDR_POWER_MODE_REQUEST;
    // Cycles spent restarting; saturates so a stuck restart cannot wrap
    always_ff @(posedge mclk or negedge reset_n)
        if (!reset_n) off_count <= 12'h000;
        else if (subsys_power_en || in_standby || in_powerdown) off_count <= 12'h000;
        else if (off_count != 12'hFFF) off_count <= off_count + 12'h001;
    // ==========================================================
    // Assertions
    property p_mr_start;
        w_rc && reg_wdata[4] && (in_standby || in_powerdown) && !module_reset |-> ##[1:2] (module_reset && coef_clear_start);
    endproperty
    a_mr_start: assert property (p_mr_start) else $error("module reset not started");
    property p_mr_len;
        $rose(module_reset) |-> module_reset [*8] ##12 module_reset ##1 !module_reset;
    endproperty
    a_mr_len: assert property (p_mr_len) else $error("module reset length wrong");
    property p_mr_refuse;
        w_rc && reg_wdata[4] && subsys_power_en |=> !module_reset [*2];
    endproperty
    a_mr_refuse: assert property (p_mr_refuse) else $error("module reset taken in run");
    property p_rr;
        w_rc && reg_wdata[0] |-> ##[1:3] (exec_rom_select && processor_reset);
    endproperty
    a_rr: assert property (p_rr) else $error("register reset had no effect");
    property p_sb;
        w_pm && reg_wdata[4] && !reg_wdata[0] |-> ##2 (in_standby && charge_pump_en && !subsys_power_en);
    endproperty
    a_sb: assert property (p_sb) else $error("standby not entered");
    property p_pd;
        w_pm && reg_wdata[0] |-> ##2 (in_powerdown && !in_standby && !charge_pump_en && !subsys_power_en);
    endproperty
    a_pd: assert property (p_pd) else $error("powerdown not entered");
    property p_ce;
        clock_error && !in_powerdown |-> ##[1:2] (in_standby && !subsys_power_en);
    endproperty
    a_ce: assert property (p_ce) else $error("clock error ignored");
    property p_sup;
        $past(reset_n) |-> digital_supply_en;
    endproperty
    a_sup: assert property (p_sup) else $error("digital supply off");
    property p_restart;
        $rose(subsys_power_en) |-> off_count >= 12'h0BE;
    endproperty
    a_restart: assert property (p_restart) else $error("restart too short");
    c_mr: cover property ($rose(module_reset));
    c_rom: cover property (exec_rom_select);
    c_pd: cover property ($rose(in_powerdown));
endmodule // reset_power_checker

bind reset_power_control reset_power_checker u_chk (.mclk(mclk), .reset_n(reset_n), .reg_write(reg_write),
    .reg_read(reg_read), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .clock_error(clock_error), .module_reset(module_reset), .processor_reset(processor_reset),
    .coef_clear_start(coef_clear_start), .exec_rom_select(exec_rom_select), .subsys_power_en(subsys_power_en),
    .charge_pump_en(charge_pump_en), .digital_supply_en(digital_supply_en), .in_standby(in_standby),
    .in_powerdown(in_powerdown), .left_mute_request(left_mute_request), .right_mute_request(right_mute_request));

// ---- verilog/power_mode_if.sv ----
`timescale 1ns/1ps
interface power_mode_if;
    import reset_power_pkg::*;
    logic standby_request;
    logic powerdown_request;
    logic clock_error;
    power_mode_t mode;

    modport ctrl (output standby_request, output powerdown_request, output clock_error, input mode);
    modport seq (input standby_request, input powerdown_request, input clock_error, output mode);
endinterface

// ---- verilog/power_sequencer.sv ----
`timescale 1ns/1ps
module power_sequencer
#(
    // Restart lengths in clock cycles
    parameter int STANDBY_RESTART_LEN = reset_power_pkg::STANDBY_RESTART_CYCLES,
    parameter int POWERDOWN_RESTART_LEN = reset_power_pkg::POWERDOWN_RESTART_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Mode requests and state
    power_mode_if.seq pm,
    // Power controls
    output logic subsys_power_en,
    output logic charge_pump_en
);
    import reset_power_pkg::*;

    typedef struct packed {
        power_mode_t mode;
        logic [COUNT_W-1:0] count;
        logic subsys;
        logic pump;
    } seq_state_t;

    seq_state_t s;
    seq_state_t next_s;

    // Powerdown must restart slower than standby, and both must fit the counter
    if (STANDBY_RESTART_LEN < 1 || POWERDOWN_RESTART_LEN >= (1 << COUNT_W)
        || POWERDOWN_RESTART_LEN <= STANDBY_RESTART_LEN)
    begin : g_bad_restart_len
        $error("power_sequencer: restart lengths do not fit");
    end

    // ==========================================================
    // Mode selection
    always_comb
    begin
        next_s = s;
        if (pm.powerdown_request)
        begin
            next_s.mode = MODE_POWERDOWN;
            next_s.count = COUNT_W'(POWERDOWN_RESTART_LEN);
        end
        else if (pm.standby_request || pm.clock_error)
        begin
            next_s.mode = MODE_STANDBY;
            // Powerdown's longer count is kept only on the first cycle in standby; a longer stay reloads the standby count
            if (s.mode != MODE_POWERDOWN)
                next_s.count = COUNT_W'(STANDBY_RESTART_LEN);
        end
        else
        begin
            case (s.mode)
                MODE_STANDBY, MODE_POWERDOWN:
                    next_s.mode = MODE_RESTART;
                MODE_RESTART:
                begin
                    if (s.count <= COUNT_W'(1))
                        next_s.mode = MODE_RUN;
                    next_s.count = s.count - COUNT_W'(1);
                end
                default:
                    next_s.mode = s.mode;
            endcase
        end
        next_s.subsys = (next_s.mode == MODE_RUN);
        next_s.pump = (next_s.mode != MODE_POWERDOWN);
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            s <= '{mode: MODE_RESTART, count: COUNT_W'(STANDBY_RESTART_LEN), subsys: 1'b0, pump: 1'b1};
        else
            s <= next_s;
    end

    assign pm.mode = s.mode;
    assign subsys_power_en = s.subsys;
    assign charge_pump_en = s.pump;

endmodule // power_sequencer

// ---- verilog/reset_power_control.sv ----
`timescale 1ns/1ps
module reset_power_control
#(
    // Lengths in clock cycles
    parameter int MODULE_RESET_LEN = reset_power_pkg::MODULE_RESET_CYCLES,
    parameter int STANDBY_RESTART_LEN = reset_power_pkg::STANDBY_RESTART_CYCLES,
    parameter int POWERDOWN_RESTART_LEN = reset_power_pkg::POWERDOWN_RESTART_CYCLES
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Control port register access
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Status input
    input wire logic clock_error,
    // Reset outputs
    output logic module_reset,
    output logic processor_reset,
    output logic coef_clear_start,
    output logic exec_rom_select,
    // Power outputs
    output logic subsys_power_en,
    output logic charge_pump_en,
    output logic digital_supply_en,
    output logic in_standby,
    output logic in_powerdown,
    // Mute outputs
    output logic left_mute_request,
    output logic right_mute_request
);
    import reset_power_pkg::*;

    // ==========================================================
    // State
    typedef struct packed {
        logic module_reset_bit;
        logic register_reset_bit;
        logic [COUNT_W-1:0] mr_count;
        logic processor_reset_bit;
        logic standby_request_bit;
        logic powerdown_request_bit;
        logic left_mute_request_bit;
        logic right_mute_request_bit;
        logic coef_clear;
        logic rom_select;
        logic [7:0] rdata;
        logic standby_flag;
        logic powerdown_flag;
        logic supply_on;
    } ctrl_state_t;

    ctrl_state_t s;
    ctrl_state_t next_s;
    power_mode_if pm ();
    logic quiet;

    // ==========================================================
    // Elaboration checks
    if (MODULE_RESET_LEN < 1 || MODULE_RESET_LEN >= (1 << COUNT_W))
    begin : g_bad_module_reset_len
        $error("reset_power_control: module reset length does not fit");
    end

    // ==========================================================
    // Power sequencer
    power_sequencer
    #(
        .STANDBY_RESTART_LEN(STANDBY_RESTART_LEN),
        .POWERDOWN_RESTART_LEN(POWERDOWN_RESTART_LEN)
    )
    u_seq
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .pm(pm),
        .subsys_power_en(subsys_power_en),
        .charge_pump_en(charge_pump_en)
    );

    assign pm.standby_request = s.standby_request_bit;
    assign pm.powerdown_request = s.powerdown_request_bit;
    assign pm.clock_error = clock_error;
    // Restart counts as not yet quiet, so a module reset cannot land mid power-up
    assign quiet = (pm.mode == MODE_STANDBY) || (pm.mode == MODE_POWERDOWN);

    // ==========================================================
    // Register and reset logic
    always_comb
    begin
        next_s = s;
        next_s.coef_clear = 1'b0;
        next_s.rom_select = 1'b0;
        next_s.supply_on = 1'b1;
        // Same priority as the sequencer, so the flags turn on the edge its mode does
        next_s.powerdown_flag = s.powerdown_request_bit;
        next_s.standby_flag = !s.powerdown_request_bit && (s.standby_request_bit || clock_error);
        if (s.register_reset_bit)
        begin
            next_s.processor_reset_bit = PROCESSOR_RESET_INIT;
            next_s.standby_request_bit = REQUEST_INIT;
            next_s.powerdown_request_bit = REQUEST_INIT;
            next_s.left_mute_request_bit = REQUEST_INIT;
            next_s.right_mute_request_bit = REQUEST_INIT;
            next_s.register_reset_bit = 1'b0;
            next_s.rom_select = 1'b1;
        end
        if (s.module_reset_bit)
        begin
            if (s.mr_count <= COUNT_W'(1))
                next_s.module_reset_bit = 1'b0;
            next_s.mr_count = s.mr_count - COUNT_W'(1);
        end
        if (reg_write)
        begin
            if (reg_addr == ADDR_RESET_CONTROL)
            begin
                // Only accepted in standby or powerdown; a running or restarting converter ignores it
                if (reg_wdata[MODULE_RESET_POS] && quiet && !s.module_reset_bit)
                begin
                    next_s.module_reset_bit = 1'b1;
                    next_s.mr_count = COUNT_W'(MODULE_RESET_LEN);
                    next_s.coef_clear = 1'b1;
                end
                if (reg_wdata[REGISTER_RESET_POS])
                    next_s.register_reset_bit = 1'b1;
            end
            else if (reg_addr == ADDR_POWER_MODE_REQUEST && !s.register_reset_bit)
            begin
                next_s.processor_reset_bit = reg_wdata[PROCESSOR_RESET_POS];
                next_s.standby_request_bit = reg_wdata[STANDBY_REQUEST_POS];
                next_s.powerdown_request_bit = reg_wdata[POWERDOWN_REQUEST_POS];
            end
            else if (reg_addr == ADDR_CHANNEL_MUTE && !s.register_reset_bit)
            begin
                next_s.left_mute_request_bit = reg_wdata[LEFT_MUTE_POS];
                next_s.right_mute_request_bit = reg_wdata[RIGHT_MUTE_POS];
            end
        end
        if (reg_read)
        begin
            next_s.rdata = READ_ZERO;
            if (reg_addr == ADDR_RESET_CONTROL)
            begin
                next_s.rdata[MODULE_RESET_POS] = s.module_reset_bit;
                next_s.rdata[REGISTER_RESET_POS] = s.register_reset_bit;
            end
            else if (reg_addr == ADDR_POWER_MODE_REQUEST)
            begin
                next_s.rdata[PROCESSOR_RESET_POS] = s.processor_reset_bit;
                next_s.rdata[STANDBY_REQUEST_POS] = s.standby_request_bit;
                next_s.rdata[POWERDOWN_REQUEST_POS] = s.powerdown_request_bit;
            end
            else if (reg_addr == ADDR_CHANNEL_MUTE)
            begin
                next_s.rdata[LEFT_MUTE_POS] = s.left_mute_request_bit;
                next_s.rdata[RIGHT_MUTE_POS] = s.right_mute_request_bit;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s <= '0;
            s.processor_reset_bit <= PROCESSOR_RESET_INIT;
        end
        else
            s <= next_s;
    end

    // ==========================================================
    // Outputs
    assign reg_rdata = s.rdata;
    assign module_reset = s.module_reset_bit;
    // Follows its own bit only; a module reset reaches the processor through module_reset
    assign processor_reset = s.processor_reset_bit;
    assign coef_clear_start = s.coef_clear;
    assign exec_rom_select = s.rom_select;
    assign digital_supply_en = s.supply_on;
    assign in_standby = s.standby_flag;
    assign in_powerdown = s.powerdown_flag;
    assign left_mute_request = s.left_mute_request_bit;
    assign right_mute_request = s.right_mute_request_bit;

endmodule // reset_power_control

// ---- verilog/reset_power_pkg.sv ----
// Functional notes
// - Setting the module-reset bit resets the interpolation filter and the converter modules.
// - A module reset also resets the signal processor, which then clears its coefficient memory.
// - The module-reset bit clears itself and is only accepted while the system is in standby; the code also accepts it in powerdown.
// - Setting the register-reset bit returns every mode register to its initial value and then clears itself.
// - A register reset leaves memory contents alone but points the processor back at its program store.
// - The processor-reset bit resets to 1, holding the processor in reset; writing 0 lets it run.
// - While the standby-request bit is set the converter is forced into system standby.
// - A clock error puts the device into the same system standby.
// - Standby powers down most subsystems but keeps the charge pump and digital supply up.
// - While the powerdown-request bit is set the device is in powerdown, with the charge pump off too.
// - With both request bits set, powerdown wins over standby.
// - Restarting from powerdown takes longer than restarting from standby.
// - Bit 0 of the mute register requests a soft mute of the right channel.
package reset_power_pkg;

    // ==========================================================
    // Register map
    localparam logic [7:0] ADDR_RESET_CONTROL = 8'h01;
    localparam logic [7:0] ADDR_POWER_MODE_REQUEST = 8'h02;
    localparam logic [7:0] ADDR_CHANNEL_MUTE = 8'h03;

    // ==========================================================
    // Field positions
    localparam int MODULE_RESET_POS = 4;
    localparam int REGISTER_RESET_POS = 0;
    localparam int PROCESSOR_RESET_POS = 7;
    localparam int STANDBY_REQUEST_POS = 4;
    localparam int POWERDOWN_REQUEST_POS = 0;
    localparam int LEFT_MUTE_POS = 4;
    localparam int RIGHT_MUTE_POS = 0;

    // ==========================================================
    // Reset values
    localparam logic PROCESSOR_RESET_INIT = 1'b1;
    localparam logic REQUEST_INIT = 1'b0;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int MODULE_RESET_NS = 100;
    localparam int STANDBY_RESTART_NS = 1000;
    localparam int POWERDOWN_RESTART_NS = 10000;
    localparam int MODULE_RESET_CYCLES = (MODULE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STANDBY_RESTART_CYCLES = (STANDBY_RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int POWERDOWN_RESTART_CYCLES = (POWERDOWN_RESTART_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int COUNT_W = 12;

    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {MODE_RUN, MODE_STANDBY, MODE_POWERDOWN, MODE_RESTART} power_mode_t;

endpackage
